// File: rtl/emi_params.svh
/*
 * Constants of the external memory interface: special-function register
 * addresses, field positions, reset values and fixed cycle counts.
 * Assumes the includer sits on the single system clock.
 */
// Overview of operation
// - Config bit selects multiplexed or separate buses
// - Multiplexed: data and low address share pins
// - Interface itself drives the address-latch strobe
// - Latch strobe high while low address shown
// - Latch strobe falls, then data with strobe
// - Separate mode: address and data unshared pins
// - Mode 00: all on-chip, wrap modulo 8 kB
// - Internal: page plus low pointer, or pointer
// - Split modes: below 8 kB on-chip, else off
// - Split, no bank: 8-bit leaves upper byte undriven
// - Split: 16-bit move drives all sixteen bits
// - Split with bank: page drives upper byte
// - Mode 11: every move goes off-chip
// - External-only: 8-bit ignores page, upper undriven
// - Off-chip move lasts parameters plus four cycles
// - Setup field bits 7:6 gives 0-3 cycles
// - Strobe width field bits 5:2 gives code+1
// - Hold field bits 1:0 gives 0-3 cycles
// - Timing register resets to all ones
// - Latch strobe high and low 1-4 cycles
`ifndef EMI_PARAMS_SVH
`define EMI_PARAMS_SVH

// ****************************************************************
// Register addresses and reset values
// ****************************************************************
`define EMI_TIMING_ADDR    8'hAF
`define EMI_CONFIG_ADDR    8'hAB
`define EMI_PAGE_ADDR      8'hAA
`define EMI_TIMING_RESET   8'hFF
`define EMI_CONFIG_RESET   8'h03
`define EMI_PAGE_RESET     8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define EMI_SETUP_MSB      7
`define EMI_SETUP_LSB      6
`define EMI_WIDTH_MSB      5
`define EMI_WIDTH_LSB      2
`define EMI_HOLD_MSB       1
`define EMI_HOLD_LSB       0
`define EMI_MUXSEL_BIT     4
`define EMI_MODE_MSB       3
`define EMI_MODE_LSB       2
`define EMI_ALE_MSB        1
`define EMI_ALE_LSB        0

// ****************************************************************
// Sizes and counts
// ****************************************************************
`define EMI_XRAM_AW        13
`define EMI_XRAM_TOP       16'h2000
`define EMI_FINISH_CYCLES  4'h3

`endif

// File: rtl/emi_pkg.sv
/*
 * Types shared by the external memory interface modules.
 * Assumes nothing of its surroundings.
 */
package emi_pkg;

   // One-hot access sequencer states
   typedef enum logic [8:0] {
      EMI_IDLE   = 9'h001,
      EMI_ONCHIP = 9'h002,
      EMI_START  = 9'h004,
      EMI_ALE_H  = 9'h008,
      EMI_ALE_L  = 9'h010,
      EMI_SETUP  = 9'h020,
      EMI_STROBE = 9'h040,
      EMI_HOLD   = 9'h080,
      EMI_FINISH = 9'h100
   } emi_state_e;

   // Memory map modes
   typedef enum logic [1:0] {
      EMI_MODE_INTERNAL = 2'h0,
      EMI_MODE_SPLIT    = 2'h1,
      EMI_MODE_BANK     = 2'h2,
      EMI_MODE_EXTERNAL = 2'h3
   } emi_mode_e;

endpackage : emi_pkg

// File: rtl/emi_xram.sv
/*
 * On-chip XRAM, 8 kB, one synchronous read/write port.
 * Assumes the caller has already wrapped the address to 13 bits.
 */
`timescale 1ns/1ps
`include "emi_params.svh"
module emi_xram
   import emi_pkg::*;
(
   input  wire logic                    clk_in,
   input  wire logic                    en_in,
   input  wire logic                    we_in,
   input  wire logic [`EMI_XRAM_AW-1:0] addr_in,
   input  wire logic [7:0]              wdata_in,
   output logic      [7:0]              rdata_out
);

   logic [7:0] mem [0:(1<<`EMI_XRAM_AW)-1];

   // Read-before-write port; no reset so it maps onto block memory
   always_ff @(posedge clk_in)
   begin
      if (en_in)
      begin
         if (we_in)
            mem[addr_in] <= wdata_in;
         rdata_out <= mem[addr_in];
      end
   end

endmodule : emi_xram

// File: rtl/emi_route.sv
/*
 * Address router: forms the effective address of an external move and
 * decides on-chip or off-chip and whether the upper byte is driven.
 * Purely combinational; the caller registers what it needs.
 */
`timescale 1ns/1ps
`include "emi_params.svh"
module emi_route
   import emi_pkg::*;
(
   input  wire logic      [1:0]  mode_in,
   input  wire logic             wide_in,
   input  wire logic      [15:0] data_pointer_16_in,
   input  wire logic      [7:0]  page_in,
   input  wire logic      [7:0]  low_ptr_in,
   output logic           [15:0] addr_out,
   output logic                  offchip_out,
   output logic                  drive_hi_out
);

   logic [15:0] eff;

   // 8-bit moves pair the page with the low pointer, 16-bit use the pointer
   assign eff = wide_in ? data_pointer_16_in : {page_in, low_ptr_in};
   assign addr_out = eff;

   // Map mode decides the target and the upper-byte drive
   always_comb
   begin
      offchip_out  = 1'b0;
      drive_hi_out = 1'b0;
      unique case (emi_mode_e'(mode_in))
         EMI_MODE_INTERNAL: offchip_out = 1'b0;
         EMI_MODE_SPLIT:
         begin
            offchip_out  = (eff >= `EMI_XRAM_TOP);
            drive_hi_out = wide_in;
         end
         EMI_MODE_BANK:
         begin
            offchip_out  = (eff >= `EMI_XRAM_TOP);
            drive_hi_out = 1'b1;
         end
         EMI_MODE_EXTERNAL:
         begin
            offchip_out  = 1'b1;
            drive_hi_out = wide_in;
         end
      endcase
   end

endmodule : emi_route

// File: rtl/emi_top.sv
/*
 * External memory interface: special-function registers, routing of
 * external moves to on-chip XRAM or to an off-chip parallel SRAM, and
 * the programmable off-chip access sequencer.
 * Assumes the core holds its request inputs stable in the request cycle,
 * and an outside transparent latch when the multiplexed bus is used.
 */
`timescale 1ns/1ps
`include "emi_params.svh"
module emi_top
   import emi_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   // Special-function register port
   input  wire logic [7:0]  sfr_addr_in,
   input  wire logic        sfr_wr_in,
   input  wire logic [7:0]  sfr_wdata_in,
   output logic      [7:0]  sfr_rdata_out,
   // Core move request
   input  wire logic        req_in,
   input  wire logic        wr_in,
   input  wire logic        wide_in,
   input  wire logic [15:0] data_pointer_16_in,
   input  wire logic [7:0]  low_ptr_in,
   input  wire logic [7:0]  wdata_in,
   output logic      [7:0]  rdata_out,
   output logic             done_out,
   output logic             busy_out,
   // Memory pins
   output logic      [7:0]  addr_hi_out,
   output logic             addr_hi_oe_n_out,
   output logic      [7:0]  addr_lo_out,
   output logic             addr_lo_oe_n_out,
   output logic      [7:0]  ad_out,
   output logic             ad_oe_n_out,
   input  wire logic [7:0]  ad_in,
   output logic             ale_out,
   output logic             rd_n_out,
   output logic             wr_n_out
);

   // ****************************************************************
   // Registers
   // ****************************************************************
   logic [7:0]  timing_reg, config_reg, page_reg;
   emi_state_e  state_reg, state_next;
   logic [3:0]  cnt_reg, cnt_next;
   logic [15:0] addr_reg;
   logic [7:0]  wdata_reg, settled_reg, rd_cap_reg;
   logic        wr_reg, drive_hi_reg;
   logic [7:0]  sync1_reg, sync2_reg, sync3_reg;
   logic [15:0] route_addr;
   logic        route_off, route_hi, mux_mode;
   logic [7:0]  xram_q;
   logic [3:0]  setup_len, width_len, hold_len, ale_len;
   logic        accept;

   assign mux_mode  = ~config_reg[`EMI_MUXSEL_BIT];
   assign setup_len = {2'h0, timing_reg[`EMI_SETUP_MSB:`EMI_SETUP_LSB]};
   assign width_len = timing_reg[`EMI_WIDTH_MSB:`EMI_WIDTH_LSB];
   assign hold_len  = {2'h0, timing_reg[`EMI_HOLD_MSB:`EMI_HOLD_LSB]};
   assign ale_len   = {2'h0, config_reg[`EMI_ALE_MSB:`EMI_ALE_LSB]};
   assign accept    = req_in && (state_reg == EMI_IDLE);

   // Register writes; timing comes out of reset at the slowest setting
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         timing_reg <= `EMI_TIMING_RESET;
         config_reg <= `EMI_CONFIG_RESET;
         page_reg   <= `EMI_PAGE_RESET;
      end
      else if (sfr_wr_in)
      begin
         if (sfr_addr_in == `EMI_TIMING_ADDR)
            timing_reg <= sfr_wdata_in;
         if (sfr_addr_in == `EMI_CONFIG_ADDR)
            config_reg <= {3'h0, sfr_wdata_in[4:0]};
         if (sfr_addr_in == `EMI_PAGE_ADDR)
            page_reg <= sfr_wdata_in;
      end
   end

   // Registered read; unmapped addresses read zero
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         sfr_rdata_out <= 8'h00;
      else
         unique case (sfr_addr_in)
            `EMI_TIMING_ADDR: sfr_rdata_out <= timing_reg;
            `EMI_CONFIG_ADDR: sfr_rdata_out <= config_reg;
            `EMI_PAGE_ADDR:   sfr_rdata_out <= page_reg;
            default:          sfr_rdata_out <= 8'h00;
         endcase
   end

   // ****************************************************************
   // Routing and on-chip memory
   // ****************************************************************
   emi_route u_route (
      .mode_in      (config_reg[`EMI_MODE_MSB:`EMI_MODE_LSB]),
      .wide_in      (wide_in),
      .data_pointer_16_in      (data_pointer_16_in),
      .page_in      (page_reg),
      .low_ptr_in   (low_ptr_in),
      .addr_out     (route_addr),
      .offchip_out  (route_off),
      .drive_hi_out (route_hi)
   );

   // Upper bits dropped, so on-chip addresses wrap every 8 kB
   emi_xram u_xram (
      .clk_in    (clk_in),
      .en_in     (accept && !route_off),
      .we_in     (wr_in),
      .addr_in   (route_addr[`EMI_XRAM_AW-1:0]),
      .wdata_in  (wdata_in),
      .rdata_out (xram_q)
   );

   // ****************************************************************
   // Access sequencer
   // ****************************************************************
   // Next state; zero-length setup and hold phases are skipped
   always_comb
   begin
      state_next = state_reg;
      cnt_next   = (cnt_reg == 4'h0) ? 4'h0 : cnt_reg - 4'h1;
      unique case (state_reg)
         EMI_IDLE:
            if (accept)
            begin
               state_next = route_off ? EMI_START : EMI_ONCHIP;
               cnt_next   = 4'h0;
            end
         EMI_ONCHIP: state_next = EMI_IDLE;
         EMI_START:
            if (mux_mode)
            begin
               state_next = EMI_ALE_H;
               cnt_next   = ale_len;
            end
            else if (setup_len != 4'h0)
            begin
               state_next = EMI_SETUP;
               cnt_next   = setup_len - 4'h1;
            end
            else
            begin
               state_next = EMI_STROBE;
               cnt_next   = width_len;
            end
         EMI_ALE_H:
            if (cnt_reg == 4'h0)
            begin
               state_next = EMI_ALE_L;
               cnt_next   = ale_len;
            end
         EMI_ALE_L:
            if (cnt_reg == 4'h0)
            begin
               state_next = (setup_len != 4'h0) ? EMI_SETUP : EMI_STROBE;
               cnt_next   = (setup_len != 4'h0) ? setup_len - 4'h1 : width_len;
            end
         EMI_SETUP:
            if (cnt_reg == 4'h0)
            begin
               state_next = EMI_STROBE;
               cnt_next   = width_len;
            end
         EMI_STROBE:
            if (cnt_reg == 4'h0)
            begin
               state_next = (hold_len != 4'h0) ? EMI_HOLD : EMI_FINISH;
               cnt_next   = (hold_len != 4'h0) ? hold_len - 4'h1 : `EMI_FINISH_CYCLES - 4'h1;
            end
         EMI_HOLD:
            if (cnt_reg == 4'h0)
            begin
               state_next = EMI_FINISH;
               cnt_next   = `EMI_FINISH_CYCLES - 4'h1;
            end
         EMI_FINISH:
            if (cnt_reg == 4'h0)
               state_next = EMI_IDLE;
      endcase
   end

   // State and phase counter
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         state_reg <= EMI_IDLE;
         cnt_reg   <= 4'h0;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
      end
   end

   // Request capture; later changes on the request inputs cannot disturb a running access
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         addr_reg     <= 16'h0000;
         wdata_reg    <= 8'h00;
         wr_reg       <= 1'b0;
         drive_hi_reg <= 1'b0;
      end
      else if (accept)
      begin
         addr_reg     <= route_addr;
         wdata_reg    <= wdata_in;
         wr_reg       <= wr_in;
         drive_hi_reg <= route_hi;
      end
   end

   // ****************************************************************
   // Read data path from the pins
   // ****************************************************************
   // Three-stage sampler; a value counts once the last two agree
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         sync1_reg   <= 8'h00;
         sync2_reg   <= 8'h00;
         sync3_reg   <= 8'h00;
         settled_reg <= 8'h00;
      end
      else
      begin
         sync1_reg <= ad_in;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         if (sync2_reg == sync3_reg)
            settled_reg <= sync3_reg;
      end
   end

   // Capture at the end of the strobe; sampler lag means short strobes
   // see data from before the pulse, so slow settings suit reads
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         rd_cap_reg <= 8'h00;
      else if (state_reg == EMI_STROBE && cnt_reg == 4'h0 && !wr_reg)
         rd_cap_reg <= settled_reg;
   end

   // Answer to the core
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         done_out  <= 1'b0;
         rdata_out <= 8'h00;
         busy_out  <= 1'b0;
      end
      else
      begin
         done_out <= (state_reg == EMI_ONCHIP) || (state_next == EMI_IDLE && state_reg == EMI_FINISH);
         busy_out <= (state_next != EMI_IDLE);
         if (state_reg == EMI_ONCHIP)
            rdata_out <= xram_q;
         else if (state_reg == EMI_FINISH && cnt_reg == 4'h0)
            rdata_out <= rd_cap_reg;
      end
   end

   // ****************************************************************
   // Pin drivers, registered from the next state
   // ****************************************************************
   logic off_next, addr_phase_next, strobe_next, data_phase_next;
   assign off_next        = !(state_next inside {EMI_IDLE, EMI_ONCHIP});
   assign addr_phase_next = state_next inside {EMI_START, EMI_ALE_H, EMI_ALE_L};
   assign strobe_next     = (state_next == EMI_STROBE);
   assign data_phase_next = state_next inside {EMI_SETUP, EMI_STROBE, EMI_HOLD};

   // Values of the access about to run; the pins load at the accept edge,
   // so the first cycle never shows the previous access's address
   logic [15:0] addr_now;
   logic [7:0]  wdata_now;
   logic        wr_now, hi_now;
   assign addr_now  = accept ? route_addr : addr_reg;
   assign wdata_now = accept ? wdata_in : wdata_reg;
   assign wr_now    = accept ? wr_in : wr_reg;
   assign hi_now    = accept ? route_hi : drive_hi_reg;

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         addr_hi_out      <= 8'h00;
         addr_hi_oe_n_out <= 1'b1;
         addr_lo_out      <= 8'h00;
         addr_lo_oe_n_out <= 1'b1;
         ad_out           <= 8'h00;
         ad_oe_n_out      <= 1'b1;
         ale_out          <= 1'b0;
         rd_n_out         <= 1'b1;
         wr_n_out         <= 1'b1;
      end
      else
      begin
         addr_hi_out      <= addr_now[15:8];
         addr_hi_oe_n_out <= !(off_next && hi_now);
         addr_lo_out      <= addr_now[7:0];
         addr_lo_oe_n_out <= !(off_next && !mux_mode);
         ale_out          <= (state_next == EMI_ALE_H) && mux_mode;
         rd_n_out         <= !(strobe_next && !wr_now);
         wr_n_out         <= !(strobe_next && wr_now);
         if (mux_mode)
         begin
            ad_out      <= addr_phase_next ? addr_now[7:0] : wdata_now;
            ad_oe_n_out <= !(addr_phase_next || (data_phase_next && wr_now));
         end
         else
         begin
            ad_out      <= wdata_now;
            ad_oe_n_out <= !(off_next && wr_now && state_next != EMI_FINISH);
         end
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   logic [4:0] low_cnt;
   logic [5:0] acc_cnt;
   logic [5:0] exp_len;
   logic       tim_written;

   // Helper counters: strobe low run and off-chip access length
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         low_cnt     <= 5'h00;
         acc_cnt     <= 6'h00;
         tim_written <= 1'b0;
      end
      else
      begin
         low_cnt <= (!rd_n_out || !wr_n_out) ? low_cnt + 5'h01 : 5'h00;
         acc_cnt <= (state_reg != EMI_IDLE && state_reg != EMI_ONCHIP) ? acc_cnt + 6'h01 : 6'h00;
         if (sfr_wr_in && sfr_addr_in == `EMI_TIMING_ADDR)
            tim_written <= 1'b1;
      end
   end
   assign exp_len = {2'h0, setup_len} + {2'h0, width_len} + 6'h01 + {2'h0, hold_len} + 6'h04
                  + (mux_mode ? {1'b0, ale_len, 1'b0} + 6'h02 : 6'h00);

   sequence s_strobe_ends;
      ($rose(rd_n_out) || $rose(wr_n_out));
   endsequence

   property p_strobe_width;
      @(posedge clk_in) disable iff (!rst_n_in)
      s_strobe_ends |-> (low_cnt == {1'b0, $past(width_len)} + 5'h01);
   endproperty
   a_strobe_width: assert property (p_strobe_width) else $error("strobe width wrong");

   property p_access_len;
      @(posedge clk_in) disable iff (!rst_n_in)
      (state_reg == EMI_FINISH && state_next == EMI_IDLE && !sfr_wr_in) |-> (acc_cnt + 6'h01 == exp_len);
   endproperty
   a_access_len: assert property (p_access_len) else $error("off-chip access length wrong");

   property p_timing_reset;
      @(posedge clk_in) disable iff (!rst_n_in)
      !tim_written |-> (timing_reg == 8'hFF);
   endproperty
   a_timing_reset: assert property (p_timing_reset) else $error("timing not at reset value");

   property p_ale_addr;
      @(posedge clk_in) disable iff (!rst_n_in)
      ale_out |-> (!ad_oe_n_out && ad_out == addr_reg[7:0] && rd_n_out && wr_n_out);
   endproperty
   a_ale_addr: assert property (p_ale_addr) else $error("address not shown with latch strobe");

   property p_no_ale_sep;
      @(posedge clk_in) disable iff (!rst_n_in)
      (!mux_mode && $stable(config_reg)) |-> !ale_out && ad_oe_n_out | !addr_lo_oe_n_out | !busy_out;
   endproperty
   a_no_ale_sep: assert property (p_no_ale_sep) else $error("latch strobe in separate-bus mode");

   property p_mux_write_data;
      @(posedge clk_in) disable iff (!rst_n_in)
      (!wr_n_out && mux_mode) |-> (!ad_oe_n_out && ad_out == wdata_reg && !ale_out);
   endproperty
   a_mux_write_data: assert property (p_mux_write_data) else $error("write data not on shared pins");

   sequence s_internal_req;
      accept && config_reg[`EMI_MODE_MSB:`EMI_MODE_LSB] == 2'h0;
   endsequence

   property p_internal_only;
      @(posedge clk_in) disable iff (!rst_n_in)
      s_internal_req |=> (state_reg == EMI_ONCHIP) ##1 (done_out && rd_n_out && wr_n_out);
   endproperty
   a_internal_only: assert property (p_internal_only) else $error("internal mode went off-chip");

   property p_external_only;
      @(posedge clk_in) disable iff (!rst_n_in)
      (accept && config_reg[`EMI_MODE_MSB:`EMI_MODE_LSB] == 2'h3) |=> (state_reg == EMI_START);
   endproperty
   a_external_only: assert property (p_external_only) else $error("external mode stayed on-chip");

   property p_upper_byte;
      @(posedge clk_in) disable iff (!rst_n_in)
      (!addr_hi_oe_n_out) |-> (drive_hi_reg && addr_hi_out == addr_reg[15:8]);
   endproperty
   a_upper_byte: assert property (p_upper_byte) else $error("upper address byte driven wrongly");

endmodule : emi_top

// File: bench/emi_sram_model.sv
/*
 * Behavioural parallel SRAM with a transparent low-address latch.
 * Assumes the pins of emi_top and a mode input from the bench.
 */
`timescale 1ns/1ps
module emi_sram_model
(
   input  wire logic       clk_in,
   input  wire logic       mux_in,
   input  wire logic [7:0] hi_in,
   input  wire logic       hi_oe_n_in,
   input  wire logic [7:0] lo_in,
   input  wire logic [7:0] ad_in,
   input  wire logic       rd_n_in,
   input  wire logic       wr_n_in,
   input  wire logic       ale_in,
   output logic      [7:0] ad_out
);
   logic [7:0]  mem [0:65535];
   logic [7:0]  latch_q;
   logic [7:0]  last_q = 8'h5A;
   logic [15:0] addr;
   // Latch passes while strobe is high and holds once it falls
   always_latch
   begin
      if (ale_in)
      begin
         latch_q = ad_in;
      end
   end
   // Undriven upper byte reads as port latches left at all ones
   assign addr   = {(hi_oe_n_in ? 8'hFF : hi_in), (mux_in ? latch_q : lo_in)};
   // A released bus toggles so stale data can never pass for a read
   assign ad_out = rd_n_in ? ~last_q : mem[addr];
   // Write data is taken on every edge that sees the strobe low
   always @(posedge clk_in)
   begin
      if (!wr_n_in)
      begin
         mem[addr] <= ad_in;
      end
      last_q <= ad_out;
   end
endmodule : emi_sram_model

// File: bench/external_memory_interface_test.sv
/*
 * Self-checking bench: register and move tasks, SRAM model on the pins.
 * Assumes emi_top with a 4 ns clock and an active-low async reset.
 */
`timescale 1ns/1ps
module external_memory_interface_test;
   localparam int DLY = 1;
   logic clk_in = 1'b0, rst_n_in = 1'b0, sfr_wr_in = 1'b0, req_in = 1'b0, wr_in = 1'b0, wide_in = 1'b0;
   logic [7:0] sfr_addr_in = 8'h00, sfr_wdata_in = 8'h00, low_ptr_in = 8'h00, wdata_in = 8'h00;
   logic [15:0] data_pointer_16_in = 16'h0000;
   logic [7:0] sfr_rdata_out, rdata_out, addr_hi_out, addr_lo_out, ad_out, ad_in, rd8, cfg, tm;
   logic done_out, busy_out, addr_hi_oe_n_out, addr_lo_oe_n_out, ad_oe_n_out, ale_out, rd_n_out, wr_n_out;
   logic [15:0] ea, eb;
   // Read widths stay at five cycles or more to cover the pin sampler lag
   logic [7:0] cfgs [6] = '{8'h1C, 8'h18, 8'h14, 8'h0C, 8'h0A, 8'h05};
   logic [7:0] tms  [6] = '{8'h10, 8'hFF, 8'h51, 8'h92, 8'h3C, 8'hD3};
   int n_mismatch = 0, checks = 0, e;

   always #2 clk_in = ~clk_in;

   emi_top dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in),
      .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out), .req_in(req_in), .wr_in(wr_in),
      .wide_in(wide_in), .data_pointer_16_in(data_pointer_16_in), .low_ptr_in(low_ptr_in), .wdata_in(wdata_in),
      .rdata_out(rdata_out), .done_out(done_out), .busy_out(busy_out), .addr_hi_out(addr_hi_out),
      .addr_hi_oe_n_out(addr_hi_oe_n_out), .addr_lo_out(addr_lo_out), .addr_lo_oe_n_out(addr_lo_oe_n_out),
      .ad_out(ad_out), .ad_oe_n_out(ad_oe_n_out), .ad_in(ad_in), .ale_out(ale_out), .rd_n_out(rd_n_out),
      .wr_n_out(wr_n_out));

   emi_sram_model sram (.clk_in(clk_in), .mux_in(~cfg[4]), .hi_in(addr_hi_out), .hi_oe_n_in(addr_hi_oe_n_out),
      .lo_in(addr_lo_out), .ad_in(ad_out), .rd_n_in(rd_n_out), .wr_n_in(wr_n_out), .ale_in(ale_out),
      .ad_out(ad_in));

   // ****************************************************************
   // Tasks: all entered and left just after a rising edge
   // ****************************************************************
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic close_out;
      if (n_mismatch == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out

   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr_in = a;
      sfr_wdata_in = d;
      sfr_wr_in = 1'b1;
      @(posedge clk_in);
      #DLY sfr_wr_in = 1'b0;
      @(posedge clk_in);
      #DLY;
   endtask : sfr_wr

   task automatic sfr_chk(input logic [7:0] a, input logic [7:0] exp);
      sfr_addr_in = a;
      @(posedge clk_in);
      #DLY check(sfr_rdata_out, exp);
   endtask : sfr_chk

   // One move; exp is the edge count from accept to done
   task automatic move(input logic w, input logic wd, input logic [15:0] dp, input logic [7:0] d, input int exp);
      int n;
      wr_in = w;
      wide_in = wd;
      data_pointer_16_in = dp;
      low_ptr_in = dp[7:0];
      wdata_in = d;
      req_in = 1'b1;
      @(posedge clk_in);
      #DLY req_in = 1'b0;
      check(busy_out, 1'b1);
      for (n = 1; n <= 300; n++)
      begin
         @(posedge clk_in);
         #DLY;
         if (done_out === 1'b1) break;
      end
      check(n, exp);
      if (n > 300) close_out();
      check(busy_out, 1'b0);
      rd8 = rdata_out;
   endtask : move

   // Setup + width + hold + 4, plus two latch phases in mux mode
   function automatic int offc(input logic [7:0] t, input logic [7:0] c);
      return t[7:6] + t[5:2] + 1 + t[1:0] + 4 + (c[4] ? 0 : 2 * (c[1:0] + 1));
   endfunction : offc

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial
   begin
      cfg = 8'h03;
      repeat (2) @(posedge clk_in);
      #DLY rst_n_in = 1'b1;
      sfr_chk(8'hAF, 8'hFF);
      sfr_chk(8'hAB, 8'h03);
      sfr_chk(8'hAA, 8'h00);
      sfr_chk(8'h00, 8'h00);
      // Internal-only: wrap at 8 kB, 8-bit move built from page and low pointer
      move(1'b1, 1'b1, 16'h2005, 8'h3C, 1);
      move(1'b0, 1'b1, 16'h0005, 8'h00, 1);
      check(rd8, 8'h3C);
      sfr_wr(8'hAA, 8'h40);
      move(1'b0, 1'b0, 16'h0005, 8'h00, 1);
      check(rd8, 8'h3C);
      // Split, bank and external modes with both bus kinds and a spread of timing codes
      for (int i = 0; i < 6; i++)
      begin
         cfg = cfgs[i];
         tm = tms[i];
         sfr_wr(8'hAB, cfg);
         sfr_wr(8'hAF, tm);
         sfr_chk(8'hAF, tm);
         e = offc(tm, cfg);
         ea = {(cfg[3:2] == 2'h2 ? 8'h40 : 8'hFF), 8'h30 + 8'(i)};
         move(1'b1, 1'b0, {8'h00, ea[7:0]}, 8'hA0 + 8'(i), e);
         move(1'b0, 1'b1, ea, 8'h00, e);
         check(rd8, 8'hA0 + 8'(i));
         eb = (cfg[3:2] == 2'h3) ? 16'h0010 + 16'(i) : 16'h1000 + 16'(i);
         move(1'b1, 1'b1, eb, 8'h50 + 8'(i), (cfg[3:2] == 2'h3) ? e : 1);
         move(1'b0, 1'b1, eb, 8'h00, (cfg[3:2] == 2'h3) ? e : 1);
         check(rd8, 8'h50 + 8'(i));
      end
      // Sweep all width codes with setup and hold riding along
      cfg = 8'h1C;
      sfr_wr(8'hAB, cfg);
      for (int c = 0; c < 16; c++)
      begin
         tm = {c[1:0], c[3:0], c[3:2]};
         sfr_wr(8'hAF, tm);
         move(1'b1, 1'b0, 16'h0077, 8'h11, offc(tm, cfg));
      end
      close_out();
   end
endmodule : external_memory_interface_test
